// ==== core/epm_pkg.sv ====
package epm_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [15:0] IDX_LATCH     = 16'hFE44;
	localparam logic [15:0] IDX_DIRECTION = 16'hFE45;
	localparam logic [15:0] IDX_FUNCTION  = 16'hFE46;
	localparam logic [15:0] IDX_TEST      = 16'hFE47;
	localparam logic [15:0] IDX_SEGMENT   = 16'hFEDC;
	localparam logic [15:0] IDX_RMW_OP    = 16'hFEE0;
	localparam logic [15:0] IDX_LATCH_RAW = 16'hFEE1;

	localparam int          ADDR_W        = 18;

	localparam logic [17:0] ADDR_LATCH     = {IDX_LATCH, 2'b00};
	localparam logic [17:0] ADDR_DIRECTION = {IDX_DIRECTION, 2'b00};
	localparam logic [17:0] ADDR_FUNCTION  = {IDX_FUNCTION, 2'b00};
	localparam logic [17:0] ADDR_TEST      = {IDX_TEST, 2'b00};
	localparam logic [17:0] ADDR_SEGMENT   = {IDX_SEGMENT, 2'b00};
	localparam logic [17:0] ADDR_RMW_OP    = {IDX_RMW_OP, 2'b00};
	localparam logic [17:0] ADDR_LATCH_RAW = {IDX_LATCH_RAW, 2'b00};

	// Reset values
	localparam logic [7:0] RST_LATCH     = 8'h00;
	localparam logic [7:0] RST_DIRECTION = 8'h00;
	localparam logic [7:0] RST_FUNCTION  = 8'h00;
	localparam logic [7:0] RST_SEGMENT   = 8'h00;
	localparam logic [1:0] RST_TEST_CTL  = 2'h0;

	// Test register layout
	localparam int         TST_INT_LEVEL = 1;
	localparam int         TST_RT_OUT    = 2;
	localparam logic [7:0] TST_READ_ONES = 8'h78;

	// Read-modify-write operation word fields
	localparam int RMW_OP_LSB  = 0;
	localparam int RMW_BIT_LSB = 3;

	typedef enum logic [2:0] {
		RMW_NONE = 3'h0,
		RMW_SET  = 3'h1,
		RMW_CLR  = 3'h2,
		RMW_NOT  = 3'h3,
		RMW_INC  = 3'h4,
		RMW_DEC  = 3'h5
	} epm_rmw_t;

endpackage : epm_pkg

// ==== core/epm_port.sv ====
// Behaviour
// - Direction bit 1 makes a pin output, 0 makes it input, per bit.
// - Pull-up on only when direction is 0 and latch is 1.
// - Normal output drives latch value; a high on open-drain pins is left open.
// - Ordinary latch register read returns the sampled pin levels.
// - Read-modify-write operations use stored latch contents, not pins.
// - Pin levels readable for every pin in either direction.
// - Pin 7 function output is (pwm high AND buzzer) XOR latch.
// - Pin 6 function output is pwm low XOR latch.
// - Pin 5 function output is second serial clock OR latch.
// - Pins 4 and 3 function output is second serial data OR latch.
// - Second serial input comes from pin 4 while that unit is active.
// - Pin 2 function output is first serial clock OR latch.
// - Pins 1 and 0 function output is first serial data OR latch.
// - First serial input comes from pin 1 while that unit is active.
// - Open pin with segment bit set drives its LCD segment, pins 7..1.
// - Test bit 1 selects interrupt level; bit 2 enables counter realtime output.
// - Function bit 0 in output mode carries only the latch bit; the code gives pin 0 first serial data OR latch.
// - Open pin 0 with segment bit set drives the bottom LCD segment.
// - In halt and hold modes pin states stay as on entry.
// - Open-drain pins in output mode present a high output as open circuit.
`timescale 1ns/100ps
`default_nettype none

module epm_port
	import epm_pkg::*;
#(
	parameter int         WIDTH     = 8,
	parameter logic [7:0] OD_MASK   = 8'h00
) (
	input  wire logic              CLK,
	input  wire logic              RESETN,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output var  logic [31:0]       PRDATA,
	output var  logic              PREADY,
	output var  logic              PSLVERR,
	input  wire logic [WIDTH-1:0]  PIN_IN,
	output var  logic [WIDTH-1:0]  PIN_OUT,
	output var  logic [WIDTH-1:0]  PIN_OE,
	output var  logic [WIDTH-1:0]  PIN_PULLUP,
	input  wire logic              LOW_POWER_HOLD,
	input  wire logic              PWM_HIGH,
	input  wire logic              PWM_LOW,
	input  wire logic              BUZZER,
	input  wire logic              SER0_CLK_OUT,
	input  wire logic              SER0_DATA_OUT,
	input  wire logic              SER0_ACTIVE,
	output var  logic              SER0_DATA_IN,
	input  wire logic              SER1_CLK_OUT,
	input  wire logic              SER1_DATA_OUT,
	input  wire logic              SER1_ACTIVE,
	output var  logic              SER1_DATA_IN,
	input  wire logic [WIDTH-1:0]  LCD_SEGMENT,
	output var  logic              INT_LEVEL_SELECT,
	output var  logic              COUNTER_RT_OUT_EN
);

	logic [WIDTH-1:0] latch_q;
	logic [WIDTH-1:0] latch_d;
	logic [WIDTH-1:0] dir_q;
	logic [WIDTH-1:0] fcr_q;
	logic [WIDTH-1:0] seg_q;
	logic [1:0]       tst_q;
	logic             zero_q;
	logic             zero_d;
	logic [31:0]      prdata_d;
	logic [WIDTH-1:0] func_out;
	logic [WIDTH-1:0] port_val;
	logic [WIDTH-1:0] pin_out_d;
	logic [WIDTH-1:0] pin_oe_d;
	logic [WIDTH-1:0] pullup_d;
	logic [WIDTH-1:0] open_mode;
	logic [WIDTH-1:0] rmw_result;
	logic [WIDTH-1:0] bit_mask;

	wire setup    = PSEL & ~PENABLE;
	wire wr_take  = PSEL & PENABLE & PREADY & PWRITE;
	wire hit_lat  = (PADDR == ADDR_LATCH);
	wire hit_dir  = (PADDR == ADDR_DIRECTION);
	wire hit_fcr  = (PADDR == ADDR_FUNCTION);
	wire hit_tst  = (PADDR == ADDR_TEST);
	wire hit_seg  = (PADDR == ADDR_SEGMENT);
	wire hit_rmw  = (PADDR == ADDR_RMW_OP);
	wire hit_raw  = (PADDR == ADDR_LATCH_RAW);
	wire hit_any  = hit_lat | hit_dir | hit_fcr | hit_tst | hit_seg
		| hit_rmw | hit_raw;

	wire [2:0] rmw_op  = PWDATA[RMW_OP_LSB +: 3];
	wire [2:0] rmw_bit = PWDATA[RMW_BIT_LSB +: 3];

	// Read mux; the plain latch address reads the pins themselves
	always_comb begin
		prdata_d = 32'h0000_0000;
		if (hit_lat) begin
			prdata_d[WIDTH-1:0] = PIN_IN;
		end else if (hit_dir) begin
			prdata_d[WIDTH-1:0] = dir_q;
		end else if (hit_fcr) begin
			prdata_d[WIDTH-1:0] = fcr_q;
		end else if (hit_tst) begin
			prdata_d[7:0] = TST_READ_ONES | {5'h00, tst_q, 1'b0};
		end else if (hit_seg) begin
			prdata_d[WIDTH-1:0] = seg_q;
		end else if (hit_rmw) begin
			prdata_d[0] = zero_q;
		end else if (hit_raw) begin
			prdata_d[WIDTH-1:0] = latch_q;
		end
	end

	// Bit and counter operations work on the stored latch
	always_comb begin
		bit_mask = WIDTH'(1) << rmw_bit;
		case (epm_rmw_t'(rmw_op))
			RMW_SET: rmw_result = latch_q | bit_mask;
			RMW_CLR: rmw_result = latch_q & ~bit_mask;
			RMW_NOT: rmw_result = latch_q ^ bit_mask;
			RMW_INC: rmw_result = latch_q + WIDTH'(1);
			RMW_DEC: rmw_result = latch_q - WIDTH'(1);
			default: rmw_result = latch_q;
		endcase
	end

	always_comb begin
		latch_d = latch_q;
		zero_d  = zero_q;
		if (wr_take && hit_lat) begin
			latch_d = PWDATA[WIDTH-1:0];
		end else if (wr_take && hit_rmw) begin
			latch_d = rmw_result;
			zero_d  = (rmw_result == '0);
		end
	end

	// Function mux per pin
	assign func_out[7] = (PWM_HIGH & BUZZER) ^ latch_q[7];
	assign func_out[6] = PWM_LOW ^ latch_q[6];
	assign func_out[5] = SER1_CLK_OUT | latch_q[5];
	assign func_out[4] = SER1_DATA_OUT | latch_q[4];
	assign func_out[3] = SER1_DATA_OUT | latch_q[3];
	assign func_out[2] = SER0_CLK_OUT | latch_q[2];
	assign func_out[1] = SER0_DATA_OUT | latch_q[1];
	assign func_out[0] = SER0_DATA_OUT | latch_q[0];

	assign port_val  = (fcr_q & func_out) | (~fcr_q & latch_q);
	assign open_mode = ~dir_q & ~latch_q;

	// Segment drive only in the open state; otherwise normal port logic
	always_comb begin
		for (int n = 0; n < WIDTH; n++) begin
			if (dir_q[n]) begin
				pin_oe_d[n]  = ~(OD_MASK[n] & port_val[n]);
				pin_out_d[n] = port_val[n] & ~OD_MASK[n];
			end else if (open_mode[n] && seg_q[n]) begin
				pin_oe_d[n]  = 1'b1;
				pin_out_d[n] = LCD_SEGMENT[n];
			end else begin
				pin_oe_d[n]  = 1'b0;
				pin_out_d[n] = 1'b0;
			end
		end
	end

	assign pullup_d = ~dir_q & latch_q;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			latch_q <= RST_LATCH;
			dir_q   <= RST_DIRECTION;
			fcr_q   <= RST_FUNCTION;
			seg_q   <= RST_SEGMENT;
			tst_q   <= RST_TEST_CTL;
			zero_q  <= 1'b0;
		end else begin
			latch_q <= latch_d;
			zero_q  <= zero_d;
			if (wr_take && hit_dir) begin
				dir_q <= PWDATA[WIDTH-1:0];
			end
			if (wr_take && hit_fcr) begin
				fcr_q <= PWDATA[WIDTH-1:0];
			end
			if (wr_take && hit_seg) begin
				seg_q <= PWDATA[WIDTH-1:0];
			end
			if (wr_take && hit_tst) begin
				// Bits 7 and 0 are factory test and kept at zero
				tst_q <= PWDATA[2:1];
			end
		end
	end

	// APB: data prepared in setup, answered in the first access cycle
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PRDATA  <= 32'h0000_0000;
			PREADY  <= 1'b0;
			PSLVERR <= 1'b0;
		end else begin
			PREADY  <= setup;
			PSLVERR <= setup & ~hit_any;
			if (setup && !PWRITE) begin
				PRDATA <= prdata_d;
			end
		end
	end

	// Pin drive frozen while a low-power mode holds
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			PIN_OUT    <= '0;
			PIN_OE     <= '0;
			PIN_PULLUP <= '0;
		end else if (!LOW_POWER_HOLD) begin
			PIN_OUT    <= pin_out_d;
			PIN_OE     <= pin_oe_d;
			PIN_PULLUP <= pullup_d;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			SER0_DATA_IN      <= 1'b0;
			SER1_DATA_IN      <= 1'b0;
			INT_LEVEL_SELECT  <= 1'b0;
			COUNTER_RT_OUT_EN <= 1'b0;
		end else begin
			if (SER0_ACTIVE) begin
				SER0_DATA_IN <= PIN_IN[1];
			end
			if (SER1_ACTIVE) begin
				SER1_DATA_IN <= PIN_IN[4];
			end
			INT_LEVEL_SELECT  <= tst_q[TST_INT_LEVEL-1];
			COUNTER_RT_OUT_EN <= tst_q[TST_RT_OUT-1];
		end
	end

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	a_pullup_map: assert property (
		!$past(LOW_POWER_HOLD) |->
			PIN_PULLUP == ($past(~dir_q) & $past(latch_q))
	) else $error("pull-up does not follow direction and latch");

	a_hold_keep: assert property (
		LOW_POWER_HOLD |=> $stable(PIN_OE) && $stable(PIN_OUT)
			&& $stable(PIN_PULLUP)
	) else $error("pins changed during low-power hold");

	a_out_low: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[0]) && !$past(fcr_q[0])
			&& !$past(latch_q[0]) |-> PIN_OE[0] && !PIN_OUT[0]
	) else $error("latch zero did not drive pin low");

	a_pwm_mux: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[7]) && $past(fcr_q[7])
			&& !OD_MASK[7] |-> PIN_OUT[7] ==
			(($past(PWM_HIGH) & $past(BUZZER)) ^ $past(latch_q[7]))
	) else $error("pin 7 function output wrong");

	a_pwm_low: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[6]) && $past(fcr_q[6])
			&& !OD_MASK[6] |->
			PIN_OUT[6] == ($past(PWM_LOW) ^ $past(latch_q[6]))
	) else $error("pin 6 function output wrong");

	a_lcd_drive: assert property (
		!$past(LOW_POWER_HOLD) && !$past(dir_q[0]) && !$past(latch_q[0])
			&& $past(seg_q[0]) |->
			PIN_OE[0] && PIN_OUT[0] == $past(LCD_SEGMENT[0])
	) else $error("open pin 0 did not drive its segment");

	a_input_mode: assert property (
		!$past(LOW_POWER_HOLD) && !$past(dir_q[5])
			&& !($past(seg_q[5]) && !$past(latch_q[5])) |-> !PIN_OE[5]
	) else $error("input pin is driven");

	a_od_open: assert property (
		(PIN_OE & PIN_OUT & OD_MASK) == '0
	) else $error("open-drain pin driven high");

	a_ser0_in: assert property (
		SER0_ACTIVE |=> SER0_DATA_IN == $past(PIN_IN[1])
	) else $error("first serial input not taken from pin 1");

	a_ser1_in: assert property (
		SER1_ACTIVE |=> SER1_DATA_IN == $past(PIN_IN[4])
	) else $error("second serial input not taken from pin 4");

	a_read_pins: assert property (
		setup && !PWRITE && hit_lat |=>
			PREADY && PRDATA[WIDTH-1:0] == $past(PIN_IN)
	) else $error("latch read did not return pin levels");

	a_rmw_set: assert property (
		wr_take && hit_rmw && rmw_op == RMW_SET |=>
			latch_q == ($past(latch_q) | (WIDTH'(1) << $past(rmw_bit)))
	) else $error("bit set did not use stored latch");

	a_latch_only: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[6]) && !$past(fcr_q[6])
			&& !OD_MASK[6] |->
			PIN_OE[6] && PIN_OUT[6] == $past(latch_q[6])
	) else $error("pin 6 does not carry its latch bit");

	a_ser1_clk: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[5]) && $past(fcr_q[5])
			&& !OD_MASK[5] |-> PIN_OUT[5] ==
			($past(SER1_CLK_OUT) | $past(latch_q[5]))
	) else $error("pin 5 function output wrong");

	a_ser1_data: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[3]) && $past(fcr_q[3])
			&& !OD_MASK[3] |-> PIN_OUT[3] ==
			($past(SER1_DATA_OUT) | $past(latch_q[3]))
	) else $error("pin 3 function output wrong");

	a_ser0_clk: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[2]) && $past(fcr_q[2])
			&& !OD_MASK[2] |-> PIN_OUT[2] ==
			($past(SER0_CLK_OUT) | $past(latch_q[2]))
	) else $error("pin 2 function output wrong");

	a_ser0_data: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[1]) && $past(fcr_q[1])
			&& !OD_MASK[1] |-> PIN_OUT[1] ==
			($past(SER0_DATA_OUT) | $past(latch_q[1]))
	) else $error("pin 1 function output wrong");

	a_lcd_top: assert property (
		!$past(LOW_POWER_HOLD) && !$past(dir_q[7]) && !$past(latch_q[7])
			&& $past(seg_q[7]) |->
			PIN_OE[7] && PIN_OUT[7] == $past(LCD_SEGMENT[7])
	) else $error("open pin 7 did not drive its segment");

	a_seg_normal: assert property (
		!$past(LOW_POWER_HOLD) && $past(dir_q[4]) && $past(seg_q[4])
			&& !$past(fcr_q[4]) && !OD_MASK[4] |->
			PIN_OE[4] && PIN_OUT[4] == $past(latch_q[4])
	) else $error("segment bit overrode output pin 4");

	a_ser0_keep: assert property (
		!SER0_ACTIVE |=> $stable(SER0_DATA_IN)
	) else $error("first serial input changed while idle");

	a_test_bits: assert property (
		wr_take && hit_tst |=> ##1
			INT_LEVEL_SELECT == $past(PWDATA[TST_INT_LEVEL], 2)
			&& COUNTER_RT_OUT_EN == $past(PWDATA[TST_RT_OUT], 2)
	) else $error("test register bits not passed on");

	a_ready_pulse: assert property (
		setup |=> (PREADY && PSLVERR == !$past(hit_any)) ##1 !PREADY
	) else $error("ready or error response wrong");

	a_raw_read: assert property (
		setup && !PWRITE && hit_raw |=>
			PRDATA[WIDTH-1:0] == $past(latch_q)
	) else $error("stored latch read wrong");

	a_latch_write: assert property (
		wr_take && hit_lat |=> latch_q == $past(PWDATA[WIDTH-1:0])
	) else $error("latch write did not land");

endmodule : epm_port

`default_nettype wire

// ==== test/epm_pins_model.sv ====
`timescale 1ns/100ps
`default_nettype none

module epm_pins_model (
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	input  wire logic [7:0] pin_pullup,
	input  wire logic [7:0] ext_val,
	input  wire logic [7:0] ext_en,
	output var  logic [7:0] pin_in
);
	// Undriven pins with no external drive and no pull-up show the inverse of the drive value
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
		| (~pin_oe & ~ext_en & (pin_pullup | ~pin_out));
endmodule : epm_pins_model

`default_nettype wire

// ==== test/epm_port_tb.sv ====
`timescale 1ns/100ps
`default_nettype none

module epm_port_tb;
	import epm_pkg::*;
	logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, hold = 0;
	logic [17:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata;
	logic pready, pslverr, pwh = 0, pwl = 0, base_timer_buzzer_output = 0, ils, crt;
	logic s0c = 0, s0d = 0, s0a = 0, s1c = 0, s1d = 0, s1a = 0, s0i, s1i;
	logic [7:0] pin_in, pout, poe, ppu, lcd = 0, xv = 0, xe = 0, l, d, sg, p;
	// Pin 0 uses the open-drain option
	localparam logic [7:0] OD_PINS = 8'h01;
	logic [2:0] b;
	logic [9:0] x;
	logic [9:0] q[$];
	int error_cnt = 0, checks_done = 0, cyc = 0;

	epm_port #(.OD_MASK(OD_PINS)) i_epm_port (.CLK(clk),
		.RESETN(resetn), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .PIN_IN(pin_in),
		.PIN_OUT(pout), .PIN_OE(poe), .PIN_PULLUP(ppu),
		.LOW_POWER_HOLD(hold), .PWM_HIGH(pwh), .PWM_LOW(pwl), .BUZZER(base_timer_buzzer_output),
		.SER0_CLK_OUT(s0c), .SER0_DATA_OUT(s0d), .SER0_ACTIVE(s0a),
		.SER0_DATA_IN(s0i), .SER1_CLK_OUT(s1c), .SER1_DATA_OUT(s1d),
		.SER1_ACTIVE(s1a), .SER1_DATA_IN(s1i), .LCD_SEGMENT(lcd),
		.INT_LEVEL_SELECT(ils), .COUNTER_RT_OUT_EN(crt));
	epm_pins_model i_epm_pins_model (.pin_out(pout), .pin_oe(poe),
		.pin_pullup(ppu), .ext_val(xv), .ext_en(xe), .pin_in(pin_in));

	initial forever #2 clk = ~clk;

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [15:0] idx, input logic [7:0] dt,
		input logic [7:0] e, input logic err);
		q.push_back({w, err, e});
		psel <= 1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, dt};
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask : apb

	task pins(input logic [7:0] o, input logic [7:0] e, input logic [7:0] p);
		repeat (2) @(posedge clk);
		chk({24'h0, pout & poe}, {24'h0, o});
		chk({24'h0, poe}, {24'h0, e});
		chk({24'h0, ppu}, {24'h0, p});
	endtask : pins

	task report_and_stop;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop

	// Oldest expectation is matched against each completed transfer
	always @(posedge clk) begin
		if (psel && penable && pready) begin
			x = q.pop_front();
			chk({31'h0, pslverr}, {31'h0, x[8]});
			if (!x[9]) chk(prdata, {24'h0, x[7:0]});
		end
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop;
		end
	end

	initial begin
		void'($urandom(32'h65FD9FCB));
		repeat (16) @(posedge clk);
		resetn <= 1;
		@(posedge clk);
		apb(0, IDX_DIRECTION, 0, RST_DIRECTION, 0);
		apb(0, IDX_FUNCTION, 0, RST_FUNCTION, 0);
		apb(0, IDX_SEGMENT, 0, RST_SEGMENT, 0);
		apb(0, IDX_TEST, 0, TST_READ_ONES, 0);
		apb(0, IDX_LATCH_RAW, 0, RST_LATCH, 0);
		apb(1, 16'hFE48, 8'hFF, 0, 1);
		apb(0, 16'hFE48, 0, 8'h00, 1);
		$display("test reset done");
		l = 8'($urandom);
		apb(1, IDX_LATCH, l, 0, 0);
		apb(1, IDX_DIRECTION, 8'hFF, 0, 0);
		pins(l & ~OD_PINS, ~(l & OD_PINS), 8'h00);
		apb(0, IDX_LATCH, 0, l, 0);
		xv <= 8'($urandom);
		xe <= 8'hF0;
		apb(1, IDX_DIRECTION, 8'h0F, 0, 0);
		pins(l & 8'h0F & ~OD_PINS, 8'h0F & ~(l & OD_PINS),
			l & 8'hF0);
		apb(0, IDX_LATCH, 0, {xv[7:4], l[3:0]}, 0);
		for (int k = 1; k < 6; k++) begin
			b = 3'($urandom);
			case (k)
				1: l[b] = 1'b1;
				2: l[b] = 1'b0;
				3: l[b] = ~l[b];
				4: l = l + 8'h01;
				default: l = l - 8'h01;
			endcase
			apb(1, IDX_RMW_OP, {2'h0, b, 3'(k)}, 0, 0);
			apb(0, IDX_LATCH_RAW, 0, l, 0);
		end
		apb(0, IDX_RMW_OP, 0, {7'h0, l == 8'h00}, 0);
		$display("test latch done");
		xe <= 8'h00;
		apb(1, IDX_DIRECTION, 8'hFF, 0, 0);
		apb(1, IDX_FUNCTION, 8'hFF, 0, 0);
		for (int k = 0; k < 6; k++) begin
			l = 8'($urandom);
			{pwh, pwl, base_timer_buzzer_output, s0c, s0d, s1c, s1d} <= 7'($urandom);
			apb(1, IDX_LATCH, l, 0, 0);
			p = {(pwh & base_timer_buzzer_output) ^ l[7], pwl ^ l[6], s1c | l[5],
				{2{s1d}} | l[4:3], s0c | l[2], {2{s0d}} | l[1:0]};
			pins(p & ~OD_PINS, ~(p & OD_PINS),
				8'h00);
		end
		$display("test function done");
		// Pins 7 and 0 always open with segment on; pin 4 output with it on
		d = (8'($urandom) & 8'h6E) | 8'h10;
		sg = 8'($urandom) | 8'h91;
		lcd <= 8'($urandom);
		apb(1, IDX_FUNCTION, 8'h00, 0, 0);
		apb(1, IDX_LATCH, 8'h00, 0, 0);
		apb(1, IDX_DIRECTION, d, 0, 0);
		apb(1, IDX_SEGMENT, sg, 0, 0);
		pins(~d & sg & lcd, d | sg, 8'h00);
		hold <= 1;
		apb(1, IDX_DIRECTION, 8'hFF, 0, 0);
		pins(~d & sg & lcd, d | sg, 8'h00);
		hold <= 0;
		pins(8'h00, 8'hFF, 8'h00);
		$display("test segment done");
		apb(1, IDX_DIRECTION, 8'h00, 0, 0);
		apb(1, IDX_SEGMENT, 8'h00, 0, 0);
		for (int k = 0; k < 4; k++) begin
			xe <= 8'h12;
			xv <= 8'($urandom);
			s0a <= 1;
			s1a <= 1;
			repeat (3) @(posedge clk);
			chk({31'h0, s0i}, {31'h0, xv[1]});
			chk({31'h0, s1i}, {31'h0, xv[4]});
		end
		$display("test serial done");
		for (int k = 1; k < 3; k++) begin
			// Reserved bits 7 and 0 are always written as zero
			apb(1, IDX_TEST, 8'(k * 2), 0, 0);
			apb(0, IDX_TEST, 0, TST_READ_ONES | 8'(k * 2), 0);
			chk({30'h0, crt, ils}, 32'(k));
		end
		$display("test control done");
		report_and_stop;
	end
endmodule : epm_port_tb

`default_nettype wire
